// [design/ptpl_char_if.sv]
// character carrier between link controller and character engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ptpl_char_if;
  logic rx_en;          // receiver armed
  logic rx_valid;       // character received, one cycle
  logic [7:0] rx_data;  // received character
  logic rx_perr;        // parity or stop fault on it
  logic tx_valid;       // character offered
  logic tx_ready;       // engine free to take it
  logic [7:0] tx_data;  // character to send

  // controller end
  modport ctl (
    output rx_en, tx_valid, tx_data,
    input rx_valid, rx_data, rx_perr, tx_ready
  );
  // engine end
  modport ser (
    input rx_en, tx_valid, tx_data,
    output rx_valid, rx_data, rx_perr, tx_ready
  );
endinterface

// [design/ptpl_map.svh]
// constants of the pulse trigger position link: timing, codes, crc
// assumes a 100 MHz reference clock; included by bare name
`ifndef PTPL_MAP_SVH
`define PTPL_MAP_SVH

// clock period in ns
`define PTPL_CLK_NS 10
// serial bit time and its cycle count
`define PTPL_BIT_NS 4000
`define PTPL_BIT_CYC ((`PTPL_BIT_NS + `PTPL_CLK_NS - 1) / `PTPL_CLK_NS)
// longest trigger width still taken as a measurement (exclusive)
`define PTPL_MEAS_MAX_NS 5000
`define PTPL_MEAS_MAX_CYC (`PTPL_MEAS_MAX_NS / `PTPL_CLK_NS)
// least trigger width taken as a data protocol request
`define PTPL_IP_MIN_NS 10000
`define PTPL_IP_MIN_CYC ((`PTPL_IP_MIN_NS + `PTPL_CLK_NS - 1) / `PTPL_CLK_NS)
// start and stop pulse width on the return line
`define PTPL_PULSE_NS 4000
`define PTPL_PULSE_CYC ((`PTPL_PULSE_NS + `PTPL_CLK_NS - 1) / `PTPL_CLK_NS)
// least gap before the first response character
`define PTPL_GAP_NS 51000
`define PTPL_GAP_CYC ((`PTPL_GAP_NS + `PTPL_CLK_NS - 1) / `PTPL_CLK_NS)
// wait limit for a command character or an echo
`define PTPL_TMO_NS 200000
`define PTPL_TMO_CYC (`PTPL_TMO_NS / `PTPL_CLK_NS)
// crc16 generator and seed
`define PTPL_CRC_POLY 16'h1021
`define PTPL_CRC_INIT 16'h0000
// response framing
`define PTPL_WORD_LEN 8'h04
`define PTPL_ERR_ID 8'hFF
`define PTPL_ERR_LEN 8'h01
`define PTPL_ERR_NONE 8'h00
`define PTPL_ERR_UNKNOWN 8'h01
`define PTPL_ERR_XMIT 8'h02
`define PTPL_ERR_MEM 8'h03
// range of word-coded commands that are answered
`define PTPL_CMD_FIRST 8'h06
`define PTPL_CMD_LAST 8'h0A

`endif

// [design/ptpl_pkg.sv]
// types of the pulse trigger position link
// assumes nothing of its surroundings
package ptpl_pkg;

  // link controller states
  typedef enum logic [2:0] {
    IDLE,
    WIDTH,
    MEAS_WAIT,
    CMD_RX,
    GAP,
    TX
  } ptpl_state_t;

  // state of the link controller
  typedef struct packed {
    ptpl_state_t st;       // controller state
    logic trig;            // trigger seen last cycle
    logic [10:0] wcnt;     // trigger width counter
    logic [9:0] pcnt;      // return pulse counter, zero when idle
    logic pend;            // stop pulse waiting for the line
    logic stopped;         // echo already taken
    logic [15:0] tcnt;     // gap and wait counter
    logic [2:0] idx;       // character index
    logic [15:0] crc;      // running crc
    logic [7:0] ci;        // received command identifier
    logic [7:0] len;       // received length
    logic [15:0] rcrc;     // received crc
    logic bad;             // parity or frame fault seen
    logic [7:0] code;      // error code, zero when fine
    logic [7:0] cmd;       // command held for the user
    logic [5:0][7:0] rsp;  // response characters
    logic [2:0] n;         // response characters before crc
    logic go;              // measurement start pulse
  } ptpl_top_st_t;

  // state of the character engine
  typedef struct packed {
    logic rx_on;           // receiving a character
    logic [9:0] rx_cnt;    // receive bit timer
    logic [3:0] rx_bit;    // receive bit index
    logic [7:0] rx_sh;     // receive data shifter
    logic rx_par;          // received parity bit
    logic rx_v;            // character complete pulse
    logic [7:0] rx_d;      // received character
    logic rx_e;            // parity or stop fault
    logic tx_on;           // sending a character
    logic [9:0] tx_cnt;    // send bit timer
    logic [3:0] tx_bit;    // send bit index
    logic [10:0] tx_sh;    // send frame shifter
    logic line;            // send line level
  } ptpl_ser_st_t;

endpackage

// [design/ptpl_ser.sv]
// character engine: 11-bit frames at one bit time per bit
// assumes synchronous line input and the released reset of the top
`timescale 1ns/1ps
`include "ptpl_map.svh"
module ptpl_ser #(
  parameter int unsigned BIT_CYC = `PTPL_BIT_CYC  // cycles per bit
) (
  input wire logic i_ref_clk,  // reference clock
  input wire logic i_rst_n,    // released reset, active low
  input wire logic i_ce,       // clock enable
  input wire logic i_line,     // trigger line level
  output logic o_line,         // send line level
  ptpl_char_if.ser ch          // character carrier
);

  ptpl_pkg::ptpl_ser_st_t q;  // registered state
  ptpl_pkg::ptpl_ser_st_t d;  // next state

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.rx_v = 1'b0;
    // receiver: idle low, start high, sampled mid bit
    if (!q.rx_on) begin
      if (ch.rx_en && i_line) begin
        d.rx_on = 1'b1;
        d.rx_cnt = '0;
        d.rx_bit = '0;
      end
    end else begin
      d.rx_cnt = (q.rx_cnt == 10'(BIT_CYC - 1)) ? '0 : q.rx_cnt + 10'h001;
      if (q.rx_cnt == 10'(BIT_CYC - 1)) begin
        d.rx_bit = q.rx_bit + 4'h1;
      end
      if (q.rx_cnt == 10'(BIT_CYC / 2)) begin
        if (q.rx_bit == 4'h0) begin
          d.rx_on = i_line;  // false start drops out
        end else if (q.rx_bit <= 4'h8) begin
          d.rx_sh = {i_line, q.rx_sh[7:1]};
        end else if (q.rx_bit == 4'h9) begin
          d.rx_par = i_line;
        end else begin
          // stop bit: deliver, flag odd parity or high stop
          d.rx_on = 1'b0;
          d.rx_v = 1'b1;
          d.rx_d = q.rx_sh;
          d.rx_e = (^q.rx_sh ^ q.rx_par) | i_line;
        end
      end
    end
    // transmitter: load a frame, shift one bit per bit time
    if (!q.tx_on) begin
      if (ch.tx_valid) begin
        d.tx_on = 1'b1;
        d.tx_cnt = '0;
        d.tx_bit = '0;
        // stop, even parity, data lsb first, start
        d.tx_sh = {1'b0, ^ch.tx_data, ch.tx_data, 1'b1};
        d.line = 1'b1;
      end
    end else begin
      d.tx_cnt = (q.tx_cnt == 10'(BIT_CYC - 1)) ? '0 : q.tx_cnt + 10'h001;
      if (q.tx_cnt == 10'(BIT_CYC - 1)) begin
        d.tx_bit = q.tx_bit + 4'h1;
        d.tx_sh = {1'b0, q.tx_sh[10:1]};
        d.line = q.tx_sh[1];
        if (q.tx_bit == 4'hA) begin
          d.tx_on = 1'b0;
          d.line = 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register, frozen while the enable is low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_line = q.line;
  assign ch.tx_ready = ~q.tx_on;
  assign ch.rx_valid = q.rx_v;
  assign ch.rx_data = q.rx_d;
  assign ch.rx_perr = q.rx_e;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_tx_frame;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (ch.tx_valid && ch.tx_ready && i_ce) |=>
      (o_line && q.tx_sh[8:1] == $past(ch.tx_data)
       && q.tx_sh[9] == ^$past(ch.tx_data) && !q.tx_sh[10]);
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("frame not loaded as start data parity stop");

  property p_bit_time;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    q.tx_cnt < 10'(BIT_CYC) && q.rx_cnt < 10'(BIT_CYC);
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("bit timer past one bit time");

  property p_lsb_first;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (q.tx_on && q.tx_cnt == 10'(BIT_CYC - 1) && q.tx_bit == 4'h0
     && i_ce) |=> o_line == $past(q.tx_sh[1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first data bit is not bit 0");

  property p_stop_low;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (q.tx_on && q.tx_bit == 4'hA) |-> !o_line;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("stop bit not low");

endmodule

// [design/ptpl_top.sv]
// pulse trigger position link: device end of the trigger and return lines
// assumes inputs synchronous to i_ref_clk and an analog echo strobe
`timescale 1ns/1ps
`include "ptpl_map.svh"
module ptpl_top #(
  parameter int unsigned GAP_CYC = `PTPL_GAP_CYC,  // start to response
  parameter int unsigned TMO_CYC = `PTPL_TMO_CYC,  // wait limit
  parameter int unsigned BIT_CYC = `PTPL_BIT_CYC   // cycles per bit
) (
  input wire logic i_ref_clk,           // reference clock
  input wire logic i_rst_n,             // reset, active low
  input wire logic i_ce,                // clock enable
  input wire logic i_trig,              // trigger line level
  input wire logic i_echo,              // echo strobe of the waveguide
  input wire logic [31:0] i_param_word, // word sent in the response
  input wire logic i_mem_err,           // parameter memory fault
  output logic o_ret,                   // timing-return line level
  output logic o_meas_start,            // measurement start pulse
  output logic o_cmd_req,               // command waiting for data
  output logic [7:0] o_cmd_id           // command identifier held
);

  localparam logic [10:0] MMAX = 11'(`PTPL_MEAS_MAX_CYC);
  localparam logic [10:0] IPMIN = 11'(`PTPL_IP_MIN_CYC);
  localparam logic [9:0] PCYC = 10'(`PTPL_PULSE_CYC);

  logic [1:0] rs_q;          // reset release chain
  logic rst_n;               // released reset
  logic ser_line;            // engine send line
  logic rise;                // trigger rising edge
  logic [7:0] tx_byte;       // character offered to the engine
  ptpl_pkg::ptpl_top_st_t q; // registered state
  ptpl_pkg::ptpl_top_st_t d; // next state
  ptpl_char_if ch ();        // character carrier

  //////////////////////////////////////////////////////////////////////
  // crc16 over one character, bit 0 first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (b[i] ^ r[15]) begin
        r = {r[14:0], 1'b0} ^ `PTPL_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.go = 1'b0;
    d.trig = i_trig;
    rise = i_trig & ~q.trig;
    tx_byte = (q.idx < q.n) ? q.rsp[q.idx] :
              (q.idx == q.n) ? q.crc[15:8] : q.crc[7:0];
    // return pulse generator, one width for start and stop
    if (q.pcnt != 10'h000) begin
      d.pcnt = (q.pcnt == PCYC) ? 10'h000 : q.pcnt + 10'h001;
    end else if (q.pend) begin
      d.pcnt = 10'h001;
      d.pend = 1'b0;
    end
    // echo armed only while the trigger may still be short
    if (i_echo && !q.stopped &&
        ((q.st == ptpl_pkg::WIDTH && q.wcnt < MMAX) ||
         q.st == ptpl_pkg::MEAS_WAIT)) begin
      d.pend = 1'b1;
      d.stopped = 1'b1;
    end
    unique case (q.st)
      ptpl_pkg::IDLE: begin
        // any rise starts a measurement and a start pulse
        if (rise) begin
          d.st = ptpl_pkg::WIDTH;
          d.wcnt = 11'h001;
          d.pcnt = 10'h001;
          d.pend = 1'b0;
          d.stopped = 1'b0;
          d.go = 1'b1;
        end
      end
      ptpl_pkg::WIDTH: begin
        if (i_trig) begin
          if (q.wcnt != IPMIN) begin
            d.wcnt = q.wcnt + 11'h001;
          end
        end else if (q.wcnt < MMAX) begin
          // short pulse: wait for the echo unless it is already taken
          d.st = q.stopped ? ptpl_pkg::IDLE : ptpl_pkg::MEAS_WAIT;
          d.tcnt = 16'h0000;
        end else if (q.wcnt >= IPMIN) begin
          // long pulse: receive a command
          d.st = ptpl_pkg::CMD_RX;
          d.tcnt = 16'h0000;
          d.idx = 3'h0;
          d.crc = `PTPL_CRC_INIT;
          d.bad = 1'b0;
        end else begin
          d.st = ptpl_pkg::IDLE;  // width between the two ranges
        end
      end
      ptpl_pkg::MEAS_WAIT: begin
        d.tcnt = q.tcnt + 16'h0001;
        if ((q.stopped && !q.pend && q.pcnt == 10'h000) ||
            q.tcnt == 16'(TMO_CYC - 1)) begin
          d.st = ptpl_pkg::IDLE;
        end
      end
      ptpl_pkg::CMD_RX: begin
        d.tcnt = q.tcnt + 16'h0001;
        if (ch.rx_valid) begin
          d.tcnt = 16'h0000;
          d.bad = q.bad | ch.rx_perr;
          d.idx = q.idx + 3'h1;
          unique case (q.idx)
            3'h0: begin
              d.ci = ch.rx_data;
              d.crc = crc_byte(q.crc, ch.rx_data);
            end
            3'h1: begin
              d.len = ch.rx_data;
              d.crc = crc_byte(q.crc, ch.rx_data);
            end
            3'h2: begin
              d.rcrc[15:8] = ch.rx_data;
            end
            default: begin
              // last character: judge the command
              d.st = ptpl_pkg::GAP;
              d.cmd = q.ci;
              if (q.bad || ch.rx_perr || q.len != 8'h00 ||
                  {q.rcrc[15:8], ch.rx_data} != q.crc) begin
                d.code = `PTPL_ERR_XMIT;
              end else if (q.ci >= `PTPL_CMD_FIRST &&
                           q.ci <= `PTPL_CMD_LAST) begin
                d.code = `PTPL_ERR_NONE;
              end else begin
                d.code = `PTPL_ERR_UNKNOWN;
              end
            end
          endcase
        end else if (q.tcnt == 16'(TMO_CYC - 1)) begin
          d.st = ptpl_pkg::IDLE;  // host gave up
        end
      end
      ptpl_pkg::GAP: begin
        d.tcnt = q.tcnt + 16'h0001;
        if (q.tcnt == 16'(GAP_CYC - 1)) begin
          d.st = ptpl_pkg::TX;
          d.idx = 3'h0;
          d.crc = `PTPL_CRC_INIT;
          if (q.code == `PTPL_ERR_NONE && !i_mem_err) begin
            // identifier, length, word most significant first
            d.rsp = {i_param_word[7:0], i_param_word[15:8],
                     i_param_word[23:16], i_param_word[31:24],
                     `PTPL_WORD_LEN, q.cmd};
            d.n = 3'h6;
          end else begin
            d.code = (q.code == `PTPL_ERR_NONE) ? `PTPL_ERR_MEM : q.code;
            d.rsp = {24'h000000, d.code, `PTPL_ERR_LEN,
                     `PTPL_ERR_ID};
            d.n = 3'h3;
          end
        end
      end
      ptpl_pkg::TX: begin
        // one character per engine handshake, crc last
        if (ch.tx_ready) begin
          if (q.idx < q.n) begin
            d.crc = crc_byte(q.crc, tx_byte);
          end
          d.idx = q.idx + 3'h1;
          if (q.idx == q.n + 3'h1) begin
            d.st = ptpl_pkg::IDLE;
          end
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // state register, frozen while the enable is low
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // character engine
  assign ch.rx_en = (q.st == ptpl_pkg::CMD_RX);
  assign ch.tx_valid = (q.st == ptpl_pkg::TX);
  assign ch.tx_data = tx_byte;

  ptpl_ser #(
    .BIT_CYC(BIT_CYC)
  ) u_ser (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_line(i_trig),
    .o_line(ser_line),
    .ch(ch)
  );

  // return line carries pulses and response characters
  assign o_ret = (q.pcnt != 10'h000) | ser_line;
  assign o_meas_start = q.go;
  assign o_cmd_req = (q.st == ptpl_pkg::GAP);
  assign o_cmd_id = q.cmd;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_rise_start;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (q.st == ptpl_pkg::IDLE && rise && i_ce) |=> (o_ret && o_meas_start);
  endproperty
  a_rise_start: assert property (p_rise_start)
    else $error("trigger rise gave no start pulse");

  property p_long_mode;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (q.st == ptpl_pkg::WIDTH && !i_trig && q.wcnt >= IPMIN && i_ce)
      |=> (q.st == ptpl_pkg::CMD_RX && q.crc == 16'h0000);
  endproperty
  a_long_mode: assert property (p_long_mode)
    else $error("long trigger did not enter data protocol");

  property p_no_stop;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (q.st == ptpl_pkg::CMD_RX) |-> (q.pcnt == 10'h000 && !q.pend);
  endproperty
  a_no_stop: assert property (p_no_stop)
    else $error("stop pulse during data protocol");

  property p_pulse_width;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (q.pcnt == 10'h001 && $past(q.pcnt) == 10'h000 && i_ce)
      |=> (q.pcnt != 10'h000)[*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("return pulse counter did not run");

  property p_pulse_max;
    @(posedge i_ref_clk) disable iff (!rst_n)
    q.pcnt <= PCYC;
  endproperty
  a_pulse_max: assert property (p_pulse_max)
    else $error("return pulse longer than allowed");

  property p_gap;
    @(posedge i_ref_clk) disable iff (!rst_n)
    $rose(q.st == ptpl_pkg::TX) |->
      ($past(q.st) == ptpl_pkg::GAP && $past(q.tcnt) == 16'(GAP_CYC - 1));
  endproperty
  a_gap: assert property (p_gap)
    else $error("response started before the gap ran out");

  property p_err_rsp;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (q.st == ptpl_pkg::TX && q.code != `PTPL_ERR_NONE) |->
      (q.rsp[0] == `PTPL_ERR_ID && q.rsp[2] == q.code && q.n == 3'h3);
  endproperty
  a_err_rsp: assert property (p_err_rsp)
    else $error("error response malformed");

  property p_crc_tail;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (ch.tx_valid && ch.tx_ready && q.idx == q.n) |->
      ch.tx_data == q.crc[15:8];
  endproperty
  a_crc_tail: assert property (p_crc_tail)
    else $error("crc high byte not sent after data");

endmodule

// [tb/ptpl_host.sv]
// host model: drives the trigger line and reads the return line
// assumes the bench clock; callers keep to one transfer at a time
`timescale 1ns/1ps
module ptpl_host #(
  parameter int BIT_CYC = 40  // cycles per serial bit
) (
  input wire logic i_ref_clk,  // reference clock
  input wire logic i_ret,      // return line from the device
  output logic o_trig          // trigger line to the device
);
  typedef logic [7:0] ptpl_bytes_t [$];  // character string

  initial o_trig = 1'b0;  // line idles low

  ////////////////////////////////////////
  // crc16 over data bits, lsb of each character first
  function automatic logic [15:0] crc(input ptpl_bytes_t q);
    logic [15:0] c;
    logic fb;
    c = 16'h0000;
    foreach (q[i]) begin
      for (int j = 0; j < 8; j++) begin
        fb = q[i][j] ^ c[15];
        c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction

  // trigger pulse of w high cycles
  task automatic trig(input int w);
    @(posedge i_ref_clk) #1 o_trig = 1'b1;
    repeat (w) @(posedge i_ref_clk);
    #1 o_trig = 1'b0;
  endtask

  // one command character, parity inverted when pbad is set
  task automatic put(input logic [7:0] b, input logic pbad);
    logic [10:0] f;
    f = {1'b0, ^b ^ pbad, b, 1'b1};
    @(posedge i_ref_clk);
    for (int k = 0; k < 11; k++) begin
      #1 o_trig = f[k];
      repeat (BIT_CYC) @(posedge i_ref_clk);
    end
    #1 o_trig = 1'b0;
  endtask

  // one response character, sampled at mid bit
  task automatic get(output logic [7:0] b, output logic ok);
    logic [10:0] f;
    int t;
    t = 0;
    ok = 1'b0;
    b = 8'h00;
    while (i_ret !== 1'b1 && t < 20000) begin
      @(posedge i_ref_clk) #1;  // look after the line has settled
      t++;
    end
    if (t >= 20000) return;
    repeat (BIT_CYC / 2) @(posedge i_ref_clk);
    for (int k = 0; k < 11; k++) begin
      f[k] = i_ret;
      if (k < 10) repeat (BIT_CYC) @(posedge i_ref_clk);
    end
    b = f[8:1];
    ok = f[0] & ~f[10] & (f[9] === ^f[8:1]);
  endtask
endmodule

// [tb/pulse_trigger_position_link_tb_top.sv]
// bench of the trigger and return lines, with a host model
// assumes shortened bit time and gap, passed to the design
`timescale 1ns/1ps
module pulse_trigger_position_link_tb_top;
  localparam int BIT = 40;  // shortened serial bit
  typedef struct packed {
    logic [7:0] ci;    // command sent
    logic [7:0] len;   // length sent
    logic [2:0] bad;   // crc, parity, memory fault
    logic [7:0] code;  // error code due, 00h when none
  } ptpl_row_t;
  localparam ptpl_row_t ROWS [11] = '{
    '{8'h05, 8'h00, 3'h0, 8'h01}, '{8'h06, 8'h00, 3'h0, 8'h00},
    '{8'h07, 8'h00, 3'h0, 8'h00}, '{8'h08, 8'h00, 3'h0, 8'h00},
    '{8'h09, 8'h00, 3'h0, 8'h00}, '{8'h0A, 8'h00, 3'h0, 8'h00},
    '{8'h0B, 8'h00, 3'h0, 8'h01}, '{8'h07, 8'h01, 3'h0, 8'h02},
    '{8'h08, 8'h00, 3'h4, 8'h02}, '{8'h09, 8'h00, 3'h2, 8'h02},
    '{8'h0A, 8'h00, 3'h1, 8'h03}};
  logic i_ref_clk, i_rst_n, i_ce, i_trig, i_echo, i_mem_err;
  logic [31:0] i_param_word;
  logic o_ret, o_meas_start, o_cmd_req;
  logic [7:0] o_cmd_id;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_go = 0;   // measurement start pulses seen
  int n_req = 0;  // cycles with a command waiting

  ////////////////////////////////////////
  ptpl_top #(.GAP_CYC(20), .TMO_CYC(3000), .BIT_CYC(BIT)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_trig(i_trig), .i_echo(i_echo), .i_param_word(i_param_word),
    .i_mem_err(i_mem_err), .o_ret(o_ret), .o_meas_start(o_meas_start),
    .o_cmd_req(o_cmd_req), .o_cmd_id(o_cmd_id));
  ptpl_host #(.BIT_CYC(BIT)) host (
    .i_ref_clk(i_ref_clk), .i_ret(o_ret), .o_trig(i_trig));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // event counters, sampled mid cycle where outputs are settled
  always @(negedge i_ref_clk) begin
    if (o_meas_start === 1'b1) n_go++;
    if (o_cmd_req === 1'b1) n_req++;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // cycles to rise and cycles high of the return line, bounded
  task automatic hi_len(output int t, output int w);
    t = 0;
    w = 0;
    while (o_ret !== 1'b1 && t < 60) @(posedge i_ref_clk) #2 t++;
    while (o_ret === 1'b1 && w < 900) @(posedge i_ref_clk) #2 w++;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #950_000;
    n_mismatch++;
    conclude;
  end

  ////////////////////////////////////////
  initial begin
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [15:0] c;
    logic [7:0] b;
    logic ok;
    int t, w;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_echo = 1'b0;
    i_mem_err = 1'b0;
    i_param_word = 32'h0;
    repeat (16) @(posedge i_ref_clk);
    chk({5'h0, o_ret, o_meas_start, o_cmd_req, o_cmd_id}, 16'h0);
    #1 i_rst_n = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    foreach (ROWS[r]) begin
      @(posedge i_ref_clk) #1;
      i_mem_err = ROWS[r].bad[0];
      i_param_word = {8'h12, ROWS[r].ci, 8'hA5, ~ROWS[r].ci};
      n_req = 0;
      fork
        host.trig(1000);
        hi_len(t, w);
      join
      chk(16'(t > 1 && t < 4), 16'h1);
      chk(16'(w), 16'd400);
      q = '{ROWS[r].ci, ROWS[r].len};
      c = host.crc(q) ^ {15'h0, ROWS[r].bad[2]};
      host.put(q[0], ROWS[r].bad[1]);
      host.put(q[1], 1'b0);
      host.put(c[15:8], 1'b0);
      host.put(c[7:0], 1'b0);
      if (ROWS[r].code == 8'h00) begin
        e = '{ROWS[r].ci, 8'h04, i_param_word[31:24],
          i_param_word[23:16], i_param_word[15:8], i_param_word[7:0]};
      end else begin
        e = '{8'hFF, 8'h01, ROWS[r].code};
      end
      c = host.crc(e);
      e.push_back(c[15:8]);
      e.push_back(c[7:0]);
      foreach (e[k]) begin
        host.get(b, ok);
        chk({15'h0, ok}, 16'h1);
        chk({8'h0, b}, {8'h0, e[k]});
      end
      chk(16'(n_req >= 20 && n_req <= 21), 16'h1);
      if (ROWS[r].code == 8'h00) chk({8'h0, o_cmd_id}, {8'h0, q[0]});
      repeat (10) @(posedge i_ref_clk);
    end
    // every taken rise starts a measurement, long ones included
    chk(16'(n_go), 16'd11);
    // reset in the middle of a start pulse
    fork
      host.trig(1000);
      begin
        repeat (100) @(posedge i_ref_clk);
        #1 i_rst_n = 1'b0;
        #1 chk({15'h0, o_ret}, 16'h0);
      end
    join
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    n_go = 0;
    // two short triggers, only the first gets an echo
    for (int k = 0; k < 2; k++) begin
      fork
        host.trig(100);
        hi_len(t, w);
      join
      chk(16'(t > 1 && t < 4), 16'h1);
      chk(16'(w), 16'd400);
      chk(16'(n_go), 16'(k + 1));
      fork
        if (k == 0) begin
          @(posedge i_ref_clk) #1 i_echo = 1'b1;
          @(posedge i_ref_clk) #1 i_echo = 1'b0;
        end
        hi_len(t, w);
      join
      chk(16'(w), (k == 0) ? 16'd400 : 16'd0);
      repeat (3200) @(posedge i_ref_clk);
    end
    // enable low for 50 cycles stretches the start pulse
    fork
      host.trig(100);
      hi_len(t, w);
      begin
        repeat (10) @(posedge i_ref_clk);
        #1 i_ce = 1'b0;
        repeat (50) @(posedge i_ref_clk);
        #1 i_ce = 1'b1;
      end
    join
    chk(16'(w), 16'd450);
    chk(16'(n_go), 16'd3);
    conclude;
  end
endmodule
